// [rtl/gfp_pkg.sv]
// gfp_pkg: shared constants and types for the fast bus protocol message handler
// assumes: both ends and the carrier interface import this package
package gfp_pkg;
	// ==========================================================
	// byte codes
	localparam logic [7:0] GFP_CHR_LF = 8'h0A;
	localparam logic [7:0] GFP_CHR_SEMI = 8'h3B;
	localparam logic [7:0] GFP_CHR_QMARK = 8'h3F;
	localparam logic [7:0] GFP_CHR_ZERO = 8'h30;
	localparam logic [7:0] GFP_CHR_ONE = 8'h31;
	// ==========================================================
	// timing
	localparam int GFP_CLK_NS = 4;
	localparam int GFP_ACQ_NS = 40;
	localparam int GFP_ACQ_CYC = (GFP_ACQ_NS + GFP_CLK_NS - 1) / GFP_CLK_NS;
	localparam int GFP_RESP_LEN = 4;
	// ==========================================================
	// command classes the user side hands to the parser
	typedef enum logic [2:0] {
		GFP_CMD_SET = 3'h0,
		GFP_CMD_QUERY = 3'h1,
		GFP_CMD_MEP_QUERY = 3'h2,
		GFP_CMD_READ = 3'h3,
		GFP_CMD_INIT = 3'h4,
		GFP_CMD_OPC = 3'h5,
		GFP_CMD_WAI = 3'h6,
		GFP_CMD_PROTO = 3'h7
	} gfp_cmd_e;
	// protocol select
	localparam logic GFP_PROTO_SCPI = 1'b1;
	localparam logic GFP_PROTO_FAST = 1'b0;
endpackage

// [rtl/gfp_bus_if.sv]
// gfp_bus_if: byte-level bus carrier between controller and instrument
// assumes: one clock; handshake is valid/ready per byte, eoi marks the last byte
interface gfp_bus_if;
	import gfp_pkg::*;
	logic [7:0] lsn_data; // controller to device byte
	logic lsn_eoi; // end flag with byte
	logic lsn_valid; // byte offered
	logic lsn_ready; // device accepts (low = hold-off)
	logic [7:0] tlk_data; // device to controller byte
	logic tlk_eoi; // last response byte
	logic tlk_valid; // device offers byte
	logic tlk_ready; // controller accepts
	logic talk; // device addressed to talk
	logic dev_clear; // device clear pulse
	logic ifc; // interface clear pulse
	logic mav; // message available status
	modport dev (input lsn_data, lsn_eoi, lsn_valid, talk, dev_clear, ifc, tlk_ready,
		output lsn_ready, tlk_data, tlk_eoi, tlk_valid, mav);
	modport ctl (output lsn_data, lsn_eoi, lsn_valid, talk, dev_clear, ifc, tlk_ready,
		input lsn_ready, tlk_data, tlk_eoi, tlk_valid, mav);
endinterface

// [rtl/gfp_acq.sv]
// gfp_acq: acquisition engine; fires a reading after a settle count
// assumes: start may be held high; it is ignored while busy; abort cancels in flight
module gfp_acq
	import gfp_pkg::*;
#(
	parameter int ACQ_CYC = GFP_ACQ_CYC
) (
	input wire logic mclk, // clock
	input wire logic rst, // sync reset
	input wire logic start, // begin acquisition
	input wire logic abort, // cancel
	input wire logic outputs_on, // source outputs enabled
	output logic busy, // acquiring
	output logic done, // reading ready pulse
	output logic [7:0] reading // reading byte
);
	logic [15:0] cnt;
	// ==========================================================
	// count down; readings only with outputs enabled
	always_ff @(posedge mclk) begin
		done <= 1'b0;
		if (rst || abort) begin
			busy <= 1'b0;
			cnt <= 16'h0000;
		end else if (start && !busy) begin
			busy <= 1'b1;
			cnt <= 16'(ACQ_CYC);
		end else if (busy && outputs_on) begin
			if (cnt <= 16'h0001) begin
				busy <= 1'b0;
				done <= 1'b1;
			end else begin
				cnt <= cnt - 16'h0001;
			end
		end
	end
	// reading value: a running sample index, enough to tell readings apart
	always_ff @(posedge mclk) begin
		if (rst) begin
			reading <= 8'h00;
		end else if (done) begin
			reading <= reading + 8'h01;
		end
	end
endmodule // gfp_acq

// [rtl/gfp_dev.sv]
// gfp_dev: instrument end of the fast bus protocol message handler
// assumes: user side classifies each command header; nv store keeps proto bit
module gfp_dev
	import gfp_pkg::*;
#(
	parameter int ACQ_CYC = GFP_ACQ_CYC
) (
	input wire logic mclk, // clock
	input wire logic rst, // sync reset
	gfp_bus_if.dev bus, // bus side
	input wire logic nv_proto, // stored protocol from nonvolatile memory
	input wire logic panel_sel_valid, // front-panel protocol select pulse
	input wire logic panel_sel_proto, // selected protocol
	input wire logic cmd_valid, // user decoder: header classified
	input wire logic [2:0] cmd_class, // gfp_cmd_e of current command
	input wire logic cmd_exec_done, // user: non-query command finished
	input wire logic cmd_error, // user: parser or command error
	input wire logic trig_bus_src, // trigger source set to bus
	input wire logic trig_count_inf, // trigger count infinite
	input wire logic outputs_on, // source outputs enabled
	output logic proto_sel, // current protocol (1 = full)
	output logic nv_write, // store protocol pulse
	output logic mep_enabled, // message exchange handling active
	output logic proto_refused, // bus protocol change refused pulse
	output logic query_error, // illegal query combination pulse
	output logic opc_flag // operation complete state
);
	typedef enum logic [2:0] {
		GFP_IDLE = 3'b000, GFP_RECV = 3'b001, GFP_HOLD = 3'b011,
		GFP_PEND = 3'b010, GFP_SEND = 3'b110
	} gfp_st_e;
	gfp_st_e st;
	logic ld_done, q_in_line, q_seen, cmd_seen, is_mep, is_read, acq_busy, acq_done;
	logic clr;
	logic [7:0] rd_val, acq_val;
	logic [1:0] idx;
	logic [1:0] next_idx;
	logic line_err; // bad query mix seen somewhere in this line
	logic boot;
	assign clr = bus.dev_clear | bus.ifc;
	// ==========================================================
	// protocol select: captured after reset, changed only from panel
	always_ff @(posedge mclk) begin
		nv_write <= 1'b0;
		proto_refused <= 1'b0;
		if (rst) begin
			boot <= 1'b1;
			proto_sel <= GFP_PROTO_SCPI;
		end else if (boot) begin
			boot <= 1'b0;
			proto_sel <= nv_proto;
		end else begin
			if (panel_sel_valid) begin
				proto_sel <= panel_sel_proto;
				nv_write <= 1'b1;
			end
			if (cmd_valid && gfp_cmd_e'(cmd_class) == GFP_CMD_PROTO)
				proto_refused <= 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) mep_enabled <= 1'b1;
		else mep_enabled <= proto_sel;
	end
	// ==========================================================
	// message framing and hold-off
	assign ld_done = bus.lsn_valid && bus.lsn_ready && bus.lsn_eoi && bus.lsn_data == GFP_CHR_LF;
	always_ff @(posedge mclk) begin
		query_error <= 1'b0;
		if (rst || clr) begin
			st <= GFP_IDLE;
			q_in_line <= 1'b0;
			cmd_seen <= 1'b0;
			is_mep <= 1'b0;
			is_read <= 1'b0;
			q_seen <= 1'b0;
			idx <= 2'b00;
			line_err <= 1'b0;
		end else begin
			case (st)
				GFP_IDLE, GFP_RECV: begin
					if (cmd_valid) begin
						st <= GFP_RECV;
						cmd_seen <= 1'b1;
						if (cmd_class inside {GFP_CMD_QUERY, GFP_CMD_MEP_QUERY, GFP_CMD_READ}) begin
							if (q_in_line || cmd_seen) begin
								query_error <= 1'b1;
								line_err <= 1'b1;
							end
							q_in_line <= 1'b1;
							is_mep <= gfp_cmd_e'(cmd_class) == GFP_CMD_MEP_QUERY;
							is_read <= gfp_cmd_e'(cmd_class) == GFP_CMD_READ;
						end else if (q_in_line) begin
							query_error <= 1'b1;
							line_err <= 1'b1;
						end
					end
					if (ld_done) begin
						st <= GFP_HOLD;
						if (!cmd_seen && !cmd_valid) st <= GFP_IDLE;
					end else if (bus.talk && !q_seen && !proto_sel && st == GFP_IDLE) begin
						is_read <= 1'b1;
						is_mep <= 1'b0;
						q_in_line <= 1'b1;
						st <= GFP_HOLD;
					end
				end
				GFP_HOLD: begin
					// the error pulse is long gone by the terminator, so the line keeps its own mark
					if (cmd_error || line_err) begin
						st <= GFP_IDLE;
						q_in_line <= 1'b0;
						line_err <= 1'b0;
						is_read <= 1'b0;
						cmd_seen <= 1'b0;
					end else if (q_in_line && (!is_read || acq_done)) begin
						st <= GFP_PEND;
						q_seen <= 1'b1;
						idx <= 2'b00;
					end else if (!q_in_line && (cmd_exec_done || cmd_class == GFP_CMD_INIT)) begin
						st <= GFP_IDLE;
						cmd_seen <= 1'b0;
					end
				end
				GFP_PEND, GFP_SEND: begin
					if (bus.talk) st <= GFP_SEND;
					else st <= GFP_PEND;
					if (bus.tlk_valid && bus.tlk_ready) begin
						idx <= idx + 2'b01;
						if (bus.tlk_eoi) begin
							st <= GFP_IDLE;
							q_in_line <= 1'b0;
							is_read <= 1'b0;
							q_seen <= 1'b0;
							cmd_seen <= 1'b0;
						end
					end
				end
				default: st <= GFP_IDLE;
			endcase
		end
	end
	// hold-off: ready only while receiving
	always_ff @(posedge mclk) begin
		if (rst) bus.lsn_ready <= 1'b0;
		else bus.lsn_ready <= (st == GFP_IDLE || st == GFP_RECV) && !ld_done && !clr;
	end
	// ==========================================================
	// acquisition: bus trigger and infinite count never complete
	gfp_acq #(.ACQ_CYC(ACQ_CYC)) u_acq (
		.mclk(mclk),
		.rst(rst),
		.start(st == GFP_HOLD && q_in_line && is_read && !acq_done && !trig_bus_src && !trig_count_inf),
		.abort(clr),
		.outputs_on(outputs_on),
		.busy(acq_busy),
		.done(acq_done),
		.reading(acq_val)
	);
	always_ff @(posedge mclk) begin
		if (rst) rd_val <= 8'h00;
		else if (acq_done) rd_val <= acq_val;
	end
	// ==========================================================
	// status and deferred formatting
	always_ff @(posedge mclk) begin
		if (rst || clr) bus.mav <= 1'b0;
		else bus.mav <= st == GFP_PEND || st == GFP_SEND;
	end
	always_ff @(posedge mclk) begin
		if (rst || clr) opc_flag <= 1'b0;
		else if (cmd_valid && gfp_cmd_e'(cmd_class) inside {GFP_CMD_OPC, GFP_CMD_WAI})
			opc_flag <= 1'b0;
		else if (st == GFP_IDLE && !acq_busy) opc_flag <= 1'b1;
	end
	// index after this edge's transfer, so the registered byte keeps pace with the count
	assign next_idx = (bus.tlk_valid && bus.tlk_ready) ? idx + 2'b01 : idx;
	// response bytes: value byte, two pads, then LF with end flag; offered only while talking
	always_ff @(posedge mclk) begin
		if (rst || clr) begin
			bus.tlk_valid <= 1'b0;
			bus.tlk_data <= 8'h00;
			bus.tlk_eoi <= 1'b0;
		end else begin
			bus.tlk_valid <= st == GFP_SEND && bus.talk && !(bus.tlk_valid && bus.tlk_ready && bus.tlk_eoi);
			bus.tlk_eoi <= next_idx == 2'(GFP_RESP_LEN - 1);
			case (next_idx)
				2'b00: bus.tlk_data <= is_mep ? (mep_enabled ? GFP_CHR_ONE : GFP_CHR_ZERO) : rd_val;
				2'b11: bus.tlk_data <= GFP_CHR_LF;
				default: bus.tlk_data <= GFP_CHR_SEMI;
			endcase
		end
	end
endmodule // gfp_dev

// [rtl/gfp_ctl.sv]
// gfp_ctl: bus controller end; sends one line then, if it holds a query, reads the answer
// assumes: user issues one line at a time; one query per line
module gfp_ctl
	import gfp_pkg::*;
(
	input wire logic mclk, // clock
	input wire logic rst, // sync reset
	gfp_bus_if.ctl bus, // bus side
	input wire logic req_valid, // user: send byte
	input wire logic [7:0] req_data, // byte, LF ends line
	input wire logic req_query, // line holds a query
	input wire logic clear_req, // user: issue device clear
	output logic req_ready, // byte taken
	output logic [7:0] rsp_data, // received byte
	output logic rsp_valid, // received pulse
	output logic rsp_last // last byte of answer
);
	logic pend;
	// ==========================================================
	// listen side: LF always goes with end flag; talk only after it
	always_ff @(posedge mclk) begin
		if (rst) begin
			bus.lsn_valid <= 1'b0;
			bus.lsn_data <= 8'h00;
			bus.lsn_eoi <= 1'b0;
			bus.talk <= 1'b0;
			bus.dev_clear <= 1'b0;
			bus.ifc <= 1'b0;
			bus.tlk_ready <= 1'b0;
			req_ready <= 1'b0;
			pend <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_data <= 8'h00;
			rsp_last <= 1'b0;
		end else begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			bus.dev_clear <= clear_req;
			bus.ifc <= 1'b0;
			if (bus.lsn_valid && bus.lsn_ready) begin
				bus.lsn_valid <= 1'b0;
				req_ready <= 1'b1;
				if (bus.lsn_eoi) pend <= 1'b1;
			end else if (req_valid && !req_ready && !bus.lsn_valid && !bus.talk) begin
				bus.lsn_valid <= 1'b1;
				bus.lsn_data <= req_data;
				bus.lsn_eoi <= req_data == GFP_CHR_LF;
				pend <= 1'b0; // a new line voids the last terminator
			end else if (pend && req_query && !bus.talk) begin
				// talk once the terminator is out; the device may still be holding off
				bus.talk <= 1'b1;
				bus.tlk_ready <= 1'b1;
			end
			if (bus.tlk_valid && bus.tlk_ready) begin
				rsp_valid <= 1'b1;
				rsp_data <= bus.tlk_data;
				rsp_last <= bus.tlk_eoi;
				if (bus.tlk_eoi) begin
					bus.talk <= 1'b0;
					bus.tlk_ready <= 1'b0;
					pend <= 1'b0;
				end
			end
			if (clear_req) begin
				pend <= 1'b0;
				bus.talk <= 1'b0;
				bus.tlk_ready <= 1'b0;
			end
		end
	end
endmodule // gfp_ctl

// [dv/gfp_chk.sv]
// gfp_chk: timing checks on the carrier between controller and instrument ends
// assumes: one clock domain; tb instantiates it beside the carrier, no bind
module gfp_chk
	import gfp_pkg::*;
(
	input wire logic mclk, // clock
	input wire logic rst, // sync reset
	input wire logic [7:0] lsn_data, // byte to device
	input wire logic lsn_eoi, // end flag
	input wire logic lsn_valid, // byte offered
	input wire logic lsn_ready, // device accepts
	input wire logic [7:0] tlk_data, // byte to controller
	input wire logic tlk_eoi, // last byte
	input wire logic tlk_valid, // device offers
	input wire logic tlk_ready, // controller accepts
	input wire logic talk, // addressed to talk
	input wire logic dev_clear, // device clear
	input wire logic ifc, // interface clear
	input wire logic mav // message available
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ==========================================================
	// helpers
	logic part; // line begun, not yet ended
	logic [2:0] tcnt; // answer bytes taken so far
	wire clr = dev_clear | ifc;
	wire ltk = lsn_valid & lsn_ready;
	wire ttk = tlk_valid & tlk_ready;
	// a clear throws away a half-sent line as well
	always_ff @(posedge mclk) begin
		if (rst || clr) part <= 1'b0;
		else if (ltk) part <= !lsn_eoi;
	end
	// count survives talk gaps, since an answer may resume later
	always_ff @(posedge mclk) begin
		if (rst || clr) tcnt <= 3'h0;
		else if (ttk) tcnt <= tlk_eoi ? 3'h0 : tcnt + 3'h1;
	end
	// ==========================================================
	// assertions
	AST_HOLD: assert property (ltk && lsn_eoi && part && !clr |=> !lsn_ready)
		else $error("no hold-off after terminator");
	AST_EOI_LF: assert property (lsn_valid && lsn_eoi |-> lsn_data == GFP_CHR_LF)
		else $error("end flag without line feed");
	AST_TALK: assert property ($rose(talk) |-> !part)
		else $error("talk before terminator");
	AST_TLK_HOLD: assert property (tlk_valid && !tlk_ready && !clr |=> !tlk_valid || $stable(tlk_data))
		else $error("offered byte changed before taken");
	AST_LAST: assert property (ttk && tlk_eoi |-> tcnt == 3'h3 && tlk_data == GFP_CHR_LF)
		else $error("answer end misplaced");
	AST_PAD: assert property (ttk && tcnt inside {3'h1, 3'h2} |-> tlk_data == GFP_CHR_SEMI)
		else $error("answer pad byte wrong");
	AST_CLR: assert property (clr |-> ##[1:2] (!mav && !tlk_valid))
		else $error("clear left output pending");
	AST_CLR_RDY: assert property (clr |-> ##[1:3] lsn_ready)
		else $error("clear left parser held");
	AST_FMT: assert property ($rose(tlk_valid) |-> $past(talk))
		else $error("answer offered before talk");
	cover property (ltk && lsn_eoi && part);
	cover property (ttk && tlk_eoi);
	cover property (clr);
endmodule // gfp_chk

// [dv/tb.sv]
// tb: drives both user sides of the controller and instrument ends
// assumes: ends meet through gfp_bus_if; gfp_chk watches the carrier
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
	$display("FAIL %s exp %h got %h", n, e, g); end end
module tb
	import gfp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst = 1'b1, nv_proto = 1'b1, panel_sel_valid = 1'b0, panel_sel_proto = 1'b0;
	logic cmd_valid = 1'b0, cmd_exec_done = 1'b0, cmd_error = 1'b0, outputs_on = 1'b1; // outputs on first
	logic trig_bus_src = 1'b0, trig_count_inf = 1'b0, req_valid = 1'b0, req_query = 1'b0, clear_req = 1'b0;
	logic [2:0] cmd_class = 3'h0;
	logic [7:0] req_data = 8'h00;
	logic proto_sel, nv_write, mep_enabled, proto_refused, query_error, opc_flag, req_ready, rsp_valid, rsp_last;
	logic [7:0] rsp_data;
	logic ref_seen = 1'b0, qe_seen = 1'b0, nvw_seen = 1'b0;
	int cmp_count = 0, n_mismatch = 0, seed = 32'h0000_2925;
	// 250 MHz
	always #2 mclk = ~mclk;
	gfp_bus_if bus ();
	gfp_dev #(.ACQ_CYC(2)) gfp_dev_inst (.mclk, .rst, .bus, .nv_proto, .panel_sel_valid, .panel_sel_proto,
		.cmd_valid, .cmd_class, .cmd_exec_done, .cmd_error, .trig_bus_src, .trig_count_inf, .outputs_on,
		.proto_sel, .nv_write, .mep_enabled, .proto_refused, .query_error, .opc_flag);
	gfp_ctl gfp_ctl_inst (.mclk, .rst, .bus, .req_valid, .req_data, .req_query, .clear_req, .req_ready,
		.rsp_data, .rsp_valid, .rsp_last);
	gfp_chk gfp_chk_inst (.mclk, .rst, .lsn_data(bus.lsn_data), .lsn_eoi(bus.lsn_eoi), .lsn_valid(bus.lsn_valid),
		.lsn_ready(bus.lsn_ready), .tlk_data(bus.tlk_data), .tlk_eoi(bus.tlk_eoi), .tlk_valid(bus.tlk_valid),
		.tlk_ready(bus.tlk_ready), .talk(bus.talk), .dev_clear(bus.dev_clear), .ifc(bus.ifc), .mav(bus.mav));
	// one-cycle pulses are latched so a later look still sees them
	always @(posedge mclk) begin
		if (proto_refused === 1'b1) ref_seen <= 1'b1;
		if (query_error === 1'b1) qe_seen <= 1'b1;
		if (nv_write === 1'b1) nvw_seen <= 1'b1;
	end
	// ==========================================================
	// tasks
	task automatic tk();
		@(posedge mclk);
		#1;
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic lost(input string what);
		n_mismatch++;
		$display("FAIL %s wait ran out", what);
		close_out();
	endtask
	// expected filler byte at a given place of an answer
	function automatic logic [7:0] exp_rsp(input int j);
		return (j == GFP_RESP_LEN - 1) ? GFP_CHR_LF : GFP_CHR_SEMI;
	endfunction
	// one line through the controller, the bench acting as header decoder
	// fin: 0 exec done, 1 error, 2 releases by itself, 3 cut short by a clear, 4 answer never comes, clear
	task automatic send(input gfp_cmd_e c, input logic q, input int n, input int ncmd, input int fin,
		input logic [7:0] v0);
		logic [7:0] rb[$];
		int k;
		req_query = q;
		cmd_class = c;
		for (int i = 0; i <= n; i++) begin
			if (fin == 3 && i == n) break;
			req_data = (i == n) ? GFP_CHR_LF : 8'h41 + 8'($random(seed) & 15);
			req_valid = 1'b1;
			cmd_valid = i < ncmd;
			if (i > 0 && i < ncmd) cmd_class = GFP_CMD_SET;
			k = 0;
			do begin
				tk();
				cmd_valid = 1'b0;
				k++;
			end while (req_ready !== 1'b1 && k < 100);
			if (k == 100) lost("send");
		end
		req_valid = 1'b0;
		if (fin >= 3) begin
			repeat (20) tk();
			`CHK("no answer", 1'b0, bus.mav)
			clear_req = 1'b1;
			tk();
			clear_req = 1'b0;
			repeat (3) tk();
			`CHK("idle", 1'b1, bus.lsn_ready)
		end else if (q) begin
			k = 0;
			do begin
				tk();
				if (rsp_valid === 1'b1) rb.push_back(rsp_data);
				k++;
			end while (!(rsp_valid === 1'b1 && rsp_last === 1'b1) && k < 300);
			if (k == 300) lost("answer");
			`CHK("count", 4, rb.size())
			for (int j = 1; j < GFP_RESP_LEN; j++) `CHK("pad", exp_rsp(j), rb[j])
			if (v0 != 8'h00) `CHK("value", v0, rb[0])
		end else begin
			tk();
			tk();
			if (fin == 0) `CHK("holdoff", 1'b0, bus.lsn_ready)
			cmd_exec_done = fin == 0;
			cmd_error = fin == 1;
			tk();
			cmd_exec_done = 1'b0;
			cmd_error = 1'b0;
			for (k = 0; k < 20 && bus.lsn_ready !== 1'b1; k++) tk();
			`CHK("release", 1'b1, bus.lsn_ready)
		end
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (2) @(posedge mclk);
		#1;
		rst = 1'b0;
		tk();
		tk();
		`CHK("proto", GFP_PROTO_SCPI, proto_sel)
		`CHK("mep", 1'b1, mep_enabled)
		send(GFP_CMD_MEP_QUERY, 1'b1, 3, 1, 0, GFP_CHR_ONE);
		send(GFP_CMD_OPC, 1'b0, 2, 1, 0, 8'h00);
		`CHK("opc", 1'b1, opc_flag)
		panel_sel_valid = 1'b1;
		tk();
		panel_sel_valid = 1'b0;
		repeat (3) tk();
		`CHK("stored", 1'b1, nvw_seen)
		`CHK("fast", GFP_PROTO_FAST, proto_sel)
		`CHK("mep off", 1'b0, mep_enabled)
		`CHK("kept", 1'b1, opc_flag)
		send(GFP_CMD_MEP_QUERY, 1'b1, 3, 1, 0, GFP_CHR_ZERO);
		send(GFP_CMD_PROTO, 1'b0, 4, 1, 1, 8'h00);
		`CHK("refused", 1'b1, ref_seen)
		`CHK("unchanged", GFP_PROTO_FAST, proto_sel)
		// random settings lines, some carrying several commands
		repeat (6) send(GFP_CMD_SET, 1'b0, 2 + ($random(seed) & 3), 1 + ($random(seed) & 1), $random(seed) & 1, 8'h00);
		send(GFP_CMD_INIT, 1'b0, 2, 1, 2, 8'h00);
		send(GFP_CMD_QUERY, 1'b0, 4, 2, 2, 8'h00);
		`CHK("combined", 1'b1, qe_seen)
		send(GFP_CMD_READ, 1'b1, 3, 1, 0, 8'h00);
		// talk after a line with no query: the device reads by itself
		send(GFP_CMD_INIT, 1'b1, 2, 1, 0, 8'h00);
		trig_bus_src = 1'b1;
		send(GFP_CMD_READ, 1'b1, 2, 1, 4, 8'h00);
		trig_bus_src = 1'b0;
		send(GFP_CMD_SET, 1'b0, 3, 1, 3, 8'h00);
		send(GFP_CMD_MEP_QUERY, 1'b1, 2, 1, 0, GFP_CHR_ZERO);
		close_out();
	end
endmodule // tb
